/* File: include/fscr_pkg.sv */
package fscr_pkg;
    // clock and cycle timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int REG_WRITE_TIME_NS = 2000;
    localparam int REG_WRITE_CYCLES = (REG_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ARRAY_OP_TIME_NS = 4000;
    localparam int ARRAY_OP_CYCLES = (ARRAY_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

    // opcodes
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] CONFIG_READ_CMD = 8'h15;
    localparam logic [7:0] LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] LATCH_CLEAR_CMD = 8'h04;

    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_LEVEL_LO = 2;
    localparam int ST_LEVEL_HI = 5;
    localparam int ST_QUAD = 6;
    localparam int ST_LOCK = 7;

    // configuration register fields
    localparam int CF_DRIVE_LO = 0;
    localparam int CF_DRIVE_HI = 2;
    localparam int CF_END = 3;
    localparam int CF_DUMMY_LO = 6;
    localparam int CF_DUMMY_HI = 7;

    // reset values
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic QUAD_RESET = 1'b0;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic END_RESET = 1'b0;
    localparam logic [2:0] DRIVE_RESET = 3'h7;
    localparam logic [1:0] DUMMY_RESET = 2'h0;

    // dummy clocks per dummy_len_sel code
    localparam logic [3:0] DUMMY_CODE0 = 4'h8;
    localparam logic [3:0] DUMMY_CODE1 = 4'h6;
    localparam logic [3:0] DUMMY_CODE2 = 4'h8;
    localparam logic [3:0] DUMMY_CODE3 = 4'hA;

    // array geometry for protection
    localparam int ADDR_W = 25;
    localparam int BLOCK_LSB = 16;
    localparam int BLOCK_W = ADDR_W - BLOCK_LSB;
    localparam logic [3:0] LEVEL_ALL = 4'hA;

    // bits moved per clock on the link
    localparam logic [2:0] STEP_SINGLE = 3'h1;
    localparam logic [2:0] STEP_QUAD = 3'h4;

    typedef enum logic [2:0] {
        OP_PAGE = 3'h0,
        OP_SMALL = 3'h1,
        OP_HALF = 3'h2,
        OP_BLOCK = 3'h3,
        OP_CHIP = 3'h4
    } fscr_op_type;

    typedef enum logic [2:0] {
        ST_CMD = 3'b000,
        ST_STAT = 3'b001,
        ST_CONF = 3'b011,
        ST_LATCHCMD = 3'b010,
        ST_SKIP = 3'b110
    } fscr_state_type;

    typedef enum logic [1:0] {
        JOB_NONE = 2'h0,
        JOB_REG = 2'h1,
        JOB_ARRAY = 2'h3
    } fscr_job_type;
endpackage : fscr_pkg

/* File: src/fscr_sync.sv */
`timescale 1ns/1ps
module fscr_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= async_i;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_o = stage2_ff;
endmodule : fscr_sync

/* File: src/fscr_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - status read answered even while busy
// - status byte driven until select rises
// - opcode in 8 single or 2 quad clocks
// - upper io lines except protect pin sio2 ignored in single mode
// - config read returns config byte, anytime
// - busy flag high during any write cycle
// - write commands accepted only with latch set
// - program/erase into protected area ignored
// - protect level changed only by register write
// - level guards area; chip erase needs zero
// - quad enable disables protect and pause pins
// - lock plus low protect pin: hw protection
// - hw protection refuses register write
// - drive strength resets to 30 ohm code
// - end select picks top or bottom
// - end select one-time, back to 0 only on reset
// - drive strength written only by register write
// - dummy select gives 8/6/8/10 clocks
// - latch set/cleared by commands, reset, completion
module fscr_regs #(
    parameter int REG_WRITE_CYCLES = fscr_pkg::REG_WRITE_CYCLES,
    parameter int ARRAY_OP_CYCLES = fscr_pkg::ARRAY_OP_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [3:0] sio_i,
    output logic [3:0] sio_o,
    output logic [3:0] sio_oe_o,
    input wire logic quad_cmd_mode_i,
    input wire logic reg_write_req_i,
    input wire logic [7:0] reg_write_status_i,
    input wire logic [7:0] reg_write_config_i,
    input wire logic reg_write_has_config_i,
    output logic reg_write_accept_o,
    output logic reg_write_reject_o,
    input wire logic op_req_i,
    input wire logic [2:0] op_kind_i,
    input wire logic [fscr_pkg::ADDR_W-1:0] op_addr_i,
    output logic op_accept_o,
    output logic op_reject_o,
    output logic write_busy_flag_o,
    output logic write_latch_flag_o,
    output logic [7:0] flash_status_o,
    output logic [7:0] flash_configuration_o,
    output logic hw_protect_mode_o,
    output logic pause_pin_enable_o,
    output logic [2:0] drive_strength_sel_o,
    output logic [3:0] dummy_clocks_o
);
    logic [5:0] pins_s;
    logic cs_n_s;
    logic sclk_s;
    logic [3:0] sio_s;

    fscr_sync #(.WIDTH(6)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({~cs_n_i, sclk_i, sio_i}),
        .sync_o(pins_s)
    );
    // select carried inverted so reset reads as deselected
    assign cs_n_s = ~pins_s[5];
    assign sclk_s = pins_s[4];
    assign sio_s = pins_s[3:0];

    // register state
    logic [3:0] level_ff, nxt_level;
    logic quad_ff, nxt_quad;
    logic lock_ff, nxt_lock;
    logic end_ff, nxt_end;
    logic [2:0] drive_ff, nxt_drive;
    logic [1:0] dummy_ff, nxt_dummy;
    logic latch_ff, nxt_latch;
    fscr_pkg::fscr_job_type job_ff, nxt_job;
    logic [fscr_pkg::TIMER_W-1:0] timer_ff, nxt_timer;
    logic [7:0] wr_status_ff, nxt_wr_status;
    logic [7:0] wr_config_ff, nxt_wr_config;
    logic wr_has_config_ff, nxt_wr_has_config;

    // serial state
    fscr_pkg::fscr_state_type state_ff, nxt_state;
    logic sclk_prev_ff, nxt_sclk_prev;
    logic cs_prev_ff, nxt_cs_prev;
    logic [7:0] shift_ff, nxt_shift;
    logic [2:0] pos_ff, nxt_pos;
    logic [3:0] sio_out_ff, nxt_sio_out;
    logic oe_ff, nxt_oe;

    logic busy;
    logic hw_protect;
    logic [7:0] status_val;
    logic [7:0] config_val;
    logic in_area;
    logic [fscr_pkg::BLOCK_W:0] prot_blocks;
    logic [fscr_pkg::BLOCK_W:0] blk;
    logic latch_set_ev;
    logic latch_clear_ev;
    logic wr_ok;
    logic op_ok;
    logic done;
    logic quad_link;

    assign busy = (job_ff != fscr_pkg::JOB_NONE);
    assign quad_link = quad_cmd_mode_i;
    // protect pin is sio2; quad operation removes its function
    assign hw_protect = lock_ff & ~sio_s[2] & ~quad_ff & ~quad_link;
    assign status_val = {lock_ff, quad_ff, level_ff, latch_ff, busy};
    assign config_val = {dummy_ff, 2'b00, end_ff, drive_ff};

    // protected block count from level
    always_comb begin
        prot_blocks = '0;
        if (level_ff >= fscr_pkg::LEVEL_ALL) begin
            prot_blocks = (fscr_pkg::BLOCK_W + 1)'(1) << fscr_pkg::BLOCK_W;
        end else if (level_ff != 4'h0) begin
            prot_blocks = (fscr_pkg::BLOCK_W + 1)'(1) << (level_ff - 4'h1);
        end
    end

    assign blk = {1'b0, op_addr_i[fscr_pkg::ADDR_W-1:fscr_pkg::BLOCK_LSB]};

    always_comb begin
        if (op_kind_i == fscr_pkg::OP_CHIP) begin
            in_area = (level_ff != 4'h0);
        end else if (end_ff) begin
            in_area = (blk < prot_blocks);
        end else begin
            in_area = (blk >= (((fscr_pkg::BLOCK_W + 1)'(1) << fscr_pkg::BLOCK_W) - prot_blocks));
        end
    end

    assign wr_ok = reg_write_req_i & latch_ff & ~busy & ~hw_protect;
    assign op_ok = op_req_i & ~reg_write_req_i & latch_ff & ~busy & ~in_area;
    assign done = busy & (timer_ff == '0);

    // register group next values
    always_comb begin
        nxt_level = level_ff;
        nxt_quad = quad_ff;
        nxt_lock = lock_ff;
        nxt_end = end_ff;
        nxt_drive = drive_ff;
        nxt_dummy = dummy_ff;
        nxt_latch = latch_ff;
        nxt_job = job_ff;
        nxt_timer = timer_ff;
        nxt_wr_status = wr_status_ff;
        nxt_wr_config = wr_config_ff;
        nxt_wr_has_config = wr_has_config_ff;
        if (done) begin
            nxt_job = fscr_pkg::JOB_NONE;
            nxt_latch = 1'b0;
            if (job_ff == fscr_pkg::JOB_REG) begin
                nxt_level = wr_status_ff[fscr_pkg::ST_LEVEL_HI:fscr_pkg::ST_LEVEL_LO];
                nxt_quad = wr_status_ff[fscr_pkg::ST_QUAD];
                nxt_lock = wr_status_ff[fscr_pkg::ST_LOCK];
                if (wr_has_config_ff) begin
                    nxt_drive = wr_config_ff[fscr_pkg::CF_DRIVE_HI:fscr_pkg::CF_DRIVE_LO];
                    nxt_end = end_ff | wr_config_ff[fscr_pkg::CF_END];
                    nxt_dummy = wr_config_ff[fscr_pkg::CF_DUMMY_HI:fscr_pkg::CF_DUMMY_LO];
                end
            end
        end else if (busy) begin
            nxt_timer = timer_ff - fscr_pkg::TIMER_W'(1);
        end else if (wr_ok) begin
            nxt_job = fscr_pkg::JOB_REG;
            nxt_timer = fscr_pkg::TIMER_W'(REG_WRITE_CYCLES - 1);
            nxt_wr_status = reg_write_status_i;
            nxt_wr_config = reg_write_config_i;
            nxt_wr_has_config = reg_write_has_config_i;
        end else if (op_ok) begin
            nxt_job = fscr_pkg::JOB_ARRAY;
            nxt_timer = fscr_pkg::TIMER_W'(ARRAY_OP_CYCLES - 1);
        end
        if (!busy && latch_clear_ev) begin
            nxt_latch = 1'b0;
        end
        if (!busy && latch_set_ev) begin
            nxt_latch = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            level_ff <= fscr_pkg::LEVEL_RESET;
            quad_ff <= fscr_pkg::QUAD_RESET;
            lock_ff <= fscr_pkg::LOCK_RESET;
            end_ff <= fscr_pkg::END_RESET;
            drive_ff <= fscr_pkg::DRIVE_RESET;
            dummy_ff <= fscr_pkg::DUMMY_RESET;
            latch_ff <= 1'b0;
            job_ff <= fscr_pkg::JOB_NONE;
            timer_ff <= '0;
            wr_status_ff <= 8'h00;
            wr_config_ff <= 8'h00;
            wr_has_config_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            quad_ff <= nxt_quad;
            lock_ff <= nxt_lock;
            end_ff <= nxt_end;
            drive_ff <= nxt_drive;
            dummy_ff <= nxt_dummy;
            latch_ff <= nxt_latch;
            job_ff <= nxt_job;
            timer_ff <= nxt_timer;
            wr_status_ff <= nxt_wr_status;
            wr_config_ff <= nxt_wr_config;
            wr_has_config_ff <= nxt_wr_has_config;
        end
    end

    // serial link edges
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic [2:0] step;
    logic [7:0] in_byte;
    logic [7:0] out_cur;
    logic [7:0] out_src;

    assign sclk_rise = ~cs_n_s & sclk_s & ~sclk_prev_ff;
    assign sclk_fall = ~cs_n_s & ~sclk_s & sclk_prev_ff;
    assign cs_rise = cs_n_s & ~cs_prev_ff;
    assign step = quad_link ? fscr_pkg::STEP_QUAD : fscr_pkg::STEP_SINGLE;
    // single mode takes sio0 only; of the upper lines only sio2 is read, as protect pin
    assign in_byte = quad_link ? {shift_ff[3:0], sio_s} : {shift_ff[6:0], sio_s[0]};
    assign out_src = (state_ff == fscr_pkg::ST_CONF) ? config_val : status_val;
    assign out_cur = (pos_ff == 3'h0) ? out_src : shift_ff;
    assign latch_set_ev = cs_rise & (state_ff == fscr_pkg::ST_LATCHCMD) & (shift_ff == fscr_pkg::LATCH_SET_CMD);
    assign latch_clear_ev = cs_rise & (state_ff == fscr_pkg::ST_LATCHCMD) & (shift_ff == fscr_pkg::LATCH_CLEAR_CMD);

    // serial group next values
    always_comb begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_pos = pos_ff;
        nxt_sio_out = sio_out_ff;
        nxt_oe = oe_ff;
        nxt_sclk_prev = sclk_s;
        nxt_cs_prev = cs_n_s;
        if (cs_n_s) begin
            nxt_state = fscr_pkg::ST_CMD;
            nxt_pos = 3'h0;
            nxt_oe = 1'b0;
        end else begin
            unique case (state_ff)
                fscr_pkg::ST_CMD: begin
                    if (sclk_rise) begin
                        nxt_shift = in_byte;
                        nxt_pos = pos_ff + step;
                        if (nxt_pos == 3'h0) begin
                            if (in_byte == fscr_pkg::STATUS_READ_CMD) begin
                                nxt_state = fscr_pkg::ST_STAT;
                            end else if (in_byte == fscr_pkg::CONFIG_READ_CMD) begin
                                nxt_state = fscr_pkg::ST_CONF;
                            end else if (in_byte == fscr_pkg::LATCH_SET_CMD ||
                                         in_byte == fscr_pkg::LATCH_CLEAR_CMD) begin
                                nxt_state = fscr_pkg::ST_LATCHCMD;
                            end else begin
                                nxt_state = fscr_pkg::ST_SKIP;
                            end
                        end
                    end
                end
                fscr_pkg::ST_STAT, fscr_pkg::ST_CONF: begin
                    if (sclk_fall) begin
                        nxt_oe = 1'b1;
                        nxt_sio_out = quad_link ? out_cur[7:4] : {2'b00, out_cur[7], 1'b0};
                        nxt_shift = quad_link ? {out_cur[3:0], 4'h0} : {out_cur[6:0], 1'b0};
                        nxt_pos = pos_ff + step;
                    end
                end
                fscr_pkg::ST_LATCHCMD: begin
                    if (sclk_rise) begin
                        nxt_state = fscr_pkg::ST_SKIP;
                    end
                end
                fscr_pkg::ST_SKIP: begin
                    nxt_state = fscr_pkg::ST_SKIP;
                end
                default: begin
                    nxt_state = fscr_pkg::ST_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff <= fscr_pkg::ST_CMD;
            shift_ff <= 8'h00;
            pos_ff <= 3'h0;
            sio_out_ff <= 4'h0;
            oe_ff <= 1'b0;
            sclk_prev_ff <= 1'b0;
            cs_prev_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            pos_ff <= nxt_pos;
            sio_out_ff <= nxt_sio_out;
            oe_ff <= nxt_oe;
            sclk_prev_ff <= nxt_sclk_prev;
            cs_prev_ff <= nxt_cs_prev;
        end
    end

    assign sio_o = sio_out_ff;
    assign sio_oe_o = (oe_ff & ~cs_n_s) ? (quad_link ? 4'hF : 4'h2) : 4'h0;

    // user-side outputs
    always_comb begin
        unique case (dummy_ff)
            2'h0: dummy_clocks_o = fscr_pkg::DUMMY_CODE0;
            2'h1: dummy_clocks_o = fscr_pkg::DUMMY_CODE1;
            2'h2: dummy_clocks_o = fscr_pkg::DUMMY_CODE2;
            2'h3: dummy_clocks_o = fscr_pkg::DUMMY_CODE3;
        endcase
    end

    assign reg_write_accept_o = wr_ok;
    assign reg_write_reject_o = reg_write_req_i & ~wr_ok;
    assign op_accept_o = op_ok;
    assign op_reject_o = op_req_i & ~op_ok;
    assign write_busy_flag_o = busy;
    assign write_latch_flag_o = latch_ff;
    assign flash_status_o = status_val;
    assign flash_configuration_o = config_val;
    assign hw_protect_mode_o = hw_protect;
    assign pause_pin_enable_o = ~quad_ff;
    assign drive_strength_sel_o = drive_ff;
endmodule : fscr_regs

/* File: test/fscr_regs_sva.sv */
`timescale 1ns/1ps
module fscr_regs_sva #(
    parameter int REG_WRITE_CYCLES = 80,
    parameter int ARRAY_OP_CYCLES = 160
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic quad_cmd_mode_i,
    input wire logic reg_write_req_i,
    input wire logic op_req_i,
    input wire logic [2:0] op_kind_i,
    input wire logic reg_write_accept_o,
    input wire logic reg_write_reject_o,
    input wire logic op_accept_o,
    input wire logic [3:0] sio_oe_o,
    input wire logic write_busy_flag_o,
    input wire logic write_latch_flag_o,
    input wire logic [7:0] flash_status_o,
    input wire logic [7:0] flash_configuration_o,
    input wire logic hw_protect_mode_o,
    input wire logic [2:0] drive_strength_sel_o,
    input wire logic [3:0] dummy_clocks_o
);
    // busy drops one edge after the timer reaches zero
    localparam int WR_DONE = REG_WRITE_CYCLES + 1;
    localparam int OP_DONE = ARRAY_OP_CYCLES + 1;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    busy_on_write_a: assert property (reg_write_accept_o |=> write_busy_flag_o)
        else $error("busy not raised after register write");
    write_done_a: assert property (reg_write_accept_o |-> ##WR_DONE (!write_busy_flag_o && !write_latch_flag_o))
        else $error("register write did not complete in time");
    op_done_a: assert property (op_accept_o |-> ##OP_DONE (!write_busy_flag_o && !write_latch_flag_o))
        else $error("array operation did not complete in time");
    latch_gate_a: assert property ((reg_write_req_i || op_req_i) && !write_latch_flag_o |-> !reg_write_accept_o && !op_accept_o)
        else $error("write accepted without latch");
    hw_refuse_a: assert property (reg_write_req_i && hw_protect_mode_o |-> reg_write_reject_o)
        else $error("register write accepted under hardware protection");
    hw_cond_a: assert property (hw_protect_mode_o |-> flash_status_o[7] && !flash_status_o[6] && !quad_cmd_mode_i)
        else $error("hardware protection without its conditions");
    chip_guard_a: assert property (op_req_i && op_kind_i == 3'h4 && flash_status_o[5:2] != 4'h0 |-> !op_accept_o)
        else $error("chip erase accepted with protect level set");
    end_sticky_a: assert property ($past(flash_configuration_o[3]) |-> flash_configuration_o[3])
        else $error("end select returned to zero");
    fixed_fields_a: assert property (flash_configuration_o[5:4] == 2'h0 && flash_status_o[1:0] == {write_latch_flag_o, write_busy_flag_o})
        else $error("fixed register fields wrong");
    field_hold_a: assert property (!$fell(write_busy_flag_o) |-> $stable(flash_status_o[5:2]) && $stable(drive_strength_sel_o))
        else $error("field changed outside register write completion");
    dummy_map_a: assert property (dummy_clocks_o == (flash_configuration_o[7:6] == 2'h3 ? 4'hA : flash_configuration_o[7:6] == 2'h1 ? 4'h6 : 4'h8))
        else $error("dummy clock count wrong");
    idle_oe_a: assert property (cs_n_i [*4] |-> sio_oe_o == 4'h0)
        else $error("io driven while deselected");
endmodule : fscr_regs_sva
bind fscr_regs fscr_regs_sva #(.REG_WRITE_CYCLES(REG_WRITE_CYCLES), .ARRAY_OP_CYCLES(ARRAY_OP_CYCLES)) u_sva (.*);

/* File: test/fscr_host.sv */
`timescale 1ns/1ps
module fscr_host (
    input wire logic wp_n_i,
    input wire logic quad_i,
    input wire logic [3:0] dev_sio_i,
    input wire logic [3:0] dev_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] sio_o
);
    logic [3:0] drv;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        drv = 4'h8;
    end
    // wire level; in quad mode released lines show the inverse of their last value, in single mode only sio1 does
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            sio_o[k] = dev_oe_i[k] ? dev_sio_i[k] : (k == 2 && !quad_i) ? wp_n_i : drv[k];
        end
    end
    task automatic frame(input logic [7:0] op, input int nb, output logic [15:0] rd);
        int n;
        n = quad_i ? 2 : 8;
        rd = 16'h0000;
        cs_n_o = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            if (quad_i) drv = op[7 - 4 * i -: 4];
            else drv = {1'b1, 1'b0, ~drv[1], op[7 - i]};
            #100 sclk_o = 1'b1;
            #100 sclk_o = 1'b0;
        end
        drv = quad_i ? ~drv : {drv[3:2], ~drv[1], drv[0]};
        for (int j = 0; j < nb * n; j++) begin
            #100 sclk_o = 1'b1;
            #100 rd = quad_i ? {rd[11:0], sio_o} : {rd[14:0], sio_o[1]};
            sclk_o = 1'b0;
        end
        #100 cs_n_o = 1'b1;
        #400;
    endtask : frame
endmodule : fscr_host

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wp_n = 1'b1;
    logic quad = 1'b0;
    logic wreq = 1'b0;
    logic oreq = 1'b0;
    logic [7:0] st_i = 8'h00;
    logic [7:0] cf_i = 8'h00;
    logic [2:0] kind = 3'h0;
    logic [24:0] addr = 25'h0000000;
    logic cs_n, sclk, wacc, wrej, oacc, orej, busy, latch, hwp, pause;
    logic [3:0] sio, sio_o, sio_oe, dmy;
    logic [7:0] st, cf;
    logic [2:0] drv_sel;
    logic [15:0] rd;
    logic [16:0] rows [4] = '{{8'h05, 1'b0, 8'h00}, {8'h05, 1'b1, 8'h00}, {8'h15, 1'b0, 8'h07}, {8'h15, 1'b1, 8'h07}};
    int failures = 0;
    int n_checks = 0;
    always #12.5 clk_i = ~clk_i;
    fscr_regs #(.REG_WRITE_CYCLES(120), .ARRAY_OP_CYCLES(40)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
        .cs_n_i(cs_n), .sclk_i(sclk), .sio_i(sio), .sio_o(sio_o), .sio_oe_o(sio_oe), .quad_cmd_mode_i(quad),
        .reg_write_req_i(wreq), .reg_write_status_i(st_i), .reg_write_config_i(cf_i),
        .reg_write_has_config_i(1'b1), .reg_write_accept_o(wacc), .reg_write_reject_o(wrej), .op_req_i(oreq),
        .op_kind_i(kind), .op_addr_i(addr), .op_accept_o(oacc), .op_reject_o(orej), .write_busy_flag_o(busy),
        .write_latch_flag_o(latch), .flash_status_o(st), .flash_configuration_o(cf), .hw_protect_mode_o(hwp),
        .pause_pin_enable_o(pause), .drive_strength_sel_o(drv_sel), .dummy_clocks_o(dmy));
    fscr_host u_host (.wp_n_i(wp_n), .quad_i(quad), .dev_sio_i(sio_o), .dev_oe_i(sio_oe), .cs_n_o(cs_n),
        .sclk_o(sclk), .sio_o(sio));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic req(input logic w, input logic [7:0] s, input logic [2:0] k, input logic [24:0] a, input logic ok);
        @(negedge clk_i);
        wreq = w;
        oreq = !w;
        st_i = s;
        kind = k;
        addr = a;
        #1 chk({14'h0000, wacc | oacc, wrej | orej}, {14'h0000, ok, !ok});
        @(negedge clk_i);
        wreq = 1'b0;
        oreq = 1'b0;
    endtask : req
    task automatic cmd(input logic [7:0] op, input logic q, input int nb, input logic [15:0] exp);
        @(negedge clk_i);
        quad = q;
        u_host.frame(op, nb, rd);
        if (nb > 0) chk(rd, exp);
    endtask : cmd
    task automatic idle;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge clk_i);
        chk(16'(busy), 16'h0000);
    endtask : idle
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #500000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (4) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (3) @(negedge clk_i);
        foreach (rows[i]) cmd(rows[i][16:9], rows[i][8], 2, {2{rows[i][7:0]}});
        cmd(8'h06, 1'b0, 0, 16'h0000);
        chk(16'(latch), 16'h0001);
        cf_i = 8'hF8;
        req(1'b1, 8'h8C, 3'h0, 25'h0, 1'b1);
        cmd(8'h05, 1'b0, 1, 16'h0003);
        idle();
        cmd(8'h05, 1'b0, 2, 16'h8C8C);
        cmd(8'h15, 1'b1, 2, 16'hC8C8);
        chk(16'(dmy), 16'h000A);
        chk(16'(drv_sel), 16'h0000);
        req(1'b1, 8'h00, 3'h0, 25'h0, 1'b0);
        wp_n = 1'b0;
        cmd(8'h06, 1'b0, 0, 16'h0000);
        chk(16'(hwp), 16'h0001);
        req(1'b1, 8'h00, 3'h0, 25'h0, 1'b0);
        quad = 1'b1;
        #1 chk(16'(hwp), 16'h0000);
        wp_n = 1'b1;
        cmd(8'h04, 1'b1, 0, 16'h0000);
        chk(16'(latch), 16'h0000);
        cmd(8'h06, 1'b1, 0, 16'h0000);
        chk(16'(latch), 16'h0001);
        req(1'b0, 8'h00, 3'h0, 25'h0000000, 1'b0);
        req(1'b0, 8'h00, 3'h4, 25'h1FFF000, 1'b0);
        req(1'b0, 8'h00, 3'h1, 25'h1FFF000, 1'b1);
        idle();
        chk(16'(latch), 16'h0000);
        cmd(8'h06, 1'b0, 0, 16'h0000);
        cmd(8'h04, 1'b0, 0, 16'h0000);
        chk(16'(latch), 16'h0000);
        cmd(8'h06, 1'b0, 0, 16'h0000);
        cf_i = 8'h00;
        req(1'b1, 8'h40, 3'h0, 25'h0, 1'b1);
        idle();
        cmd(8'h15, 1'b0, 2, 16'h0808);
        chk(16'(dmy), 16'h0008);
        chk({st, 7'h00, pause}, 16'h4000);
        @(negedge clk_i);
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk({st, cf}, 16'h0007);
        chk({5'h00, drv_sel, 7'h00, pause}, 16'h0701);
        reset_i = 1'b0;
        repeat (3) @(negedge clk_i);
        cmd(8'h05, 1'b0, 1, 16'h0000);
        wrap_up();
    end
endmodule : tb_top
